/* core/dcp_pkg.sv */
package dcp_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] OFS_PORT_LOCKOUT_STATUS = 8'h0c;
  localparam logic [7:0] OFS_WIPE_GUARD_STATUS = 8'h18;
  localparam logic [7:0] OFS_ERASE_UNLOCK_KEY = 8'h1c;
  localparam logic [7:0] OFS_OUTBOUND_MESSAGE = 8'h20;
  localparam logic [7:0] OFS_OUTBOUND_PENDING_STATUS = 8'h24;
  localparam int unsigned BIT_PORT_LOCKOUT = 0;
  localparam int unsigned BIT_SECURE_PORT_LOCKOUT = 1;
  localparam int unsigned BIT_WIPE_GUARD_FLAG = 0;
  localparam int unsigned BIT_MESSAGE_WAITING = 0;
  localparam logic [31:0] KEY_RESET = 32'h0000_0000;
  localparam logic [31:0] MSG_RESET = 32'h0000_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
endpackage

/* core/dcp_key_match.sv */
`timescale 1ns/1ps
// Firmware-side key holder with write-once lock and the key comparison.
module dcp_key_match (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic fw_key_we_i,
  input wire logic [dcp_pkg::DATA_W-1:0] fw_key_wdata_i,
  input wire logic fw_lock_we_i,
  input wire logic [dcp_pkg::DATA_W-1:0] dbg_key_i,
  output logic fw_locked_o,
  output logic keys_match_o
);
  import dcp_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] key;
    logic locked;
  } dcp_km_s;

  dcp_km_s st_reg;
  dcp_km_s st_next;

  always_comb begin
    st_next = st_reg;
    if (fw_lock_we_i) begin
      st_next.locked = 1'b1;
    end
    // The lock holds until reset, so a late key write is silently dropped.
    if (fw_key_we_i && !st_reg.locked) begin // RULE10
      st_next.key = fw_key_wdata_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{key: KEY_RESET, locked: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign fw_locked_o = st_reg.locked;
  assign keys_match_o = (st_reg.key != WORD_ZERO) && (st_reg.key == dbg_key_i); // RULE4

  a_lock_blocks_key: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE10
    st_reg.locked |=> $stable(st_reg.key))
    else $error("Firmware key changed while locked.");
  a_lock_sticky: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE10
    st_reg.locked |=> st_reg.locked)
    else $error("Lock dropped without reset.");
endmodule // dcp_key_match

/* core/dcp_ctrl_port.sv */
`timescale 1ns/1ps
// Operation
// RULE1: Protection status at 0x00C, 0 means active.
// RULE2: Erase-protection status bit 0 at 0x018.
// RULE3: Erase-protection bit loaded from nonvolatile setting.
// RULE4: Key register 0x01C; erase on nonzero match.
// RULE5: Debugger writes nonzero key equal to firmware's.
// RULE6: Mailbox data word at 0x020, resets zero.
// RULE7: Debugger mailbox write sets pending flag.
// RULE8: Transmit status reads 1 while data pending.
// RULE9: CPU mailbox read clears pending both sides.
// RULE10: Lock blocks firmware key writes until reset.
// RULE11: Writes to status words are ignored.
module dcp_ctrl_port (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic dbg_sel_i,
  input wire logic dbg_we_i,
  input wire logic [dcp_pkg::ADDR_W-1:0] dbg_addr_i,
  input wire logic [dcp_pkg::DATA_W-1:0] dbg_wdata_i,
  output logic [dcp_pkg::DATA_W-1:0] dbg_rdata_o,
  input wire logic nv_port_lockout_off_i,
  input wire logic nv_secure_port_lockout_off_i,
  input wire logic nv_wipe_guard_off_i,
  input wire logic cpu_msg_rd_i,
  output logic [dcp_pkg::DATA_W-1:0] cpu_inbound_message_o,
  output logic cpu_inbound_pending_o,
  input wire logic fw_key_we_i,
  input wire logic [dcp_pkg::DATA_W-1:0] fw_key_wdata_i,
  input wire logic fw_lock_we_i,
  output logic fw_locked_o,
  output logic full_wipe_start_o
);
  import dcp_pkg::*;

  // The read data sits in the state as well, so the debugger always sees a settled word
  // one cycle after its strobe, at the cost of one flop stage on the read path.
  typedef struct packed {
    logic strap_done;
    logic port_off;
    logic secure_off;
    logic wipe_guard_flag;
    logic [DATA_W-1:0] dbg_key;
    logic [DATA_W-1:0] message;
    logic pending;
    logic match_seen;
    logic wipe_start;
    logic [DATA_W-1:0] rdata;
  } dcp_st_s;

  dcp_st_s st_reg;
  dcp_st_s st_next;
  logic keys_match;
  logic wr;

  // The firmware key and its lock live apart so the lock can be reasoned about alone.
  dcp_key_match u_key (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .fw_key_we_i(fw_key_we_i),
    .fw_key_wdata_i(fw_key_wdata_i),
    .fw_lock_we_i(fw_lock_we_i),
    .dbg_key_i(st_reg.dbg_key),
    .fw_locked_o(fw_locked_o),
    .keys_match_o(keys_match)
  );

  // The status offsets have no write decode at all, so a write there simply falls away
  // and cannot disturb the values captured from the settings.
  assign wr = dbg_sel_i && dbg_we_i;

  always_comb begin
    st_next = st_reg;
    st_next.wipe_start = 1'b0;
    // Straps are caught on the first clock after reset release, never under reset.
    // They are never sampled again, so a setting that changes later stays hidden until reset.
    if (!st_reg.strap_done) begin // RULE3
      st_next.strap_done = 1'b1;
      st_next.port_off = nv_port_lockout_off_i;
      st_next.secure_off = nv_secure_port_lockout_off_i;
      st_next.wipe_guard_flag = nv_wipe_guard_off_i;
    end
    // The key is kept after a launch; the erase itself brings the device back to reset.
    if (wr && dbg_addr_i == OFS_ERASE_UNLOCK_KEY) begin // RULE4
      st_next.dbg_key = dbg_wdata_i;
    end
    if (cpu_msg_rd_i) begin // RULE9
      st_next.pending = 1'b0;
    end
    // A debugger write in the same cycle as the CPU read wins, so no message is lost.
    if (wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE) begin // RULE6
      st_next.message = dbg_wdata_i;
      st_next.pending = 1'b1; // RULE7
    end
    // The erase is launched once per new match, not every cycle the keys agree.
    // A new matching pair written without breaking the match first gives no second launch.
    st_next.match_seen = keys_match;
    if (keys_match && !st_reg.match_seen) begin // RULE4
      st_next.wipe_start = 1'b1;
    end
    st_next.rdata = WORD_ZERO;
    if (dbg_sel_i && !dbg_we_i) begin // RULE11
      unique case (dbg_addr_i)
        OFS_PORT_LOCKOUT_STATUS: begin // RULE1
          st_next.rdata[BIT_PORT_LOCKOUT] = st_reg.port_off;
          st_next.rdata[BIT_SECURE_PORT_LOCKOUT] = st_reg.secure_off;
        end
        OFS_WIPE_GUARD_STATUS: begin // RULE2
          st_next.rdata[BIT_WIPE_GUARD_FLAG] = st_reg.wipe_guard_flag;
        end
        OFS_ERASE_UNLOCK_KEY: begin
          st_next.rdata = st_reg.dbg_key;
        end
        OFS_OUTBOUND_MESSAGE: begin
          st_next.rdata = st_reg.message;
        end
        OFS_OUTBOUND_PENDING_STATUS: begin // RULE8
          st_next.rdata[BIT_MESSAGE_WAITING] = st_reg.pending;
        end
        default: begin
          st_next.rdata = WORD_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_reg <= '{strap_done: 1'b0, port_off: 1'b0, secure_off: 1'b0,
                  wipe_guard_flag: 1'b0, dbg_key: KEY_RESET, message: MSG_RESET,
                  pending: 1'b0, match_seen: 1'b0, wipe_start: 1'b0, rdata: WORD_ZERO};
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output comes straight from a flop, so the CPU side never sees a glitch.
  assign dbg_rdata_o = st_reg.rdata;
  assign cpu_inbound_message_o = st_reg.message;
  assign cpu_inbound_pending_o = st_reg.pending;
  assign full_wipe_start_o = st_reg.wipe_start;

  // Readback checks compare with the state one cycle earlier, when the strobe was taken.
  a_msg_sets_pend: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE
    |=> st_reg.pending && st_reg.message == $past(dbg_wdata_i))
    else $error("Mailbox write did not set pending.");
  a_read_clears: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE9
    cpu_msg_rd_i && !(wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE) |=> !st_reg.pending)
    else $error("CPU read did not clear pending.");
  a_pend_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE8
    dbg_sel_i && !dbg_we_i && dbg_addr_i == OFS_OUTBOUND_PENDING_STATUS
    |=> dbg_rdata_o == {31'h0000_0000, $past(st_reg.pending)})
    else $error("Pending status read wrong.");
  a_prot_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE1
    dbg_sel_i && !dbg_we_i && dbg_addr_i == OFS_PORT_LOCKOUT_STATUS
    |=> dbg_rdata_o == {30'h0000_0000, $past(st_reg.secure_off), $past(st_reg.port_off)})
    else $error("Protection status read wrong.");
  a_guard_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE2
    dbg_sel_i && !dbg_we_i && dbg_addr_i == OFS_WIPE_GUARD_STATUS
    |=> dbg_rdata_o == {31'h0000_0000, $past(st_reg.wipe_guard_flag)})
    else $error("Erase-protection status read wrong.");
  a_strap_stable: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    st_reg.strap_done |=> $stable(st_reg.wipe_guard_flag) && $stable(st_reg.port_off)
    && $stable(st_reg.secure_off))
    else $error("Status changed after strap capture.");
  a_strap_loaded: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE3
    !st_reg.strap_done |=> st_reg.wipe_guard_flag == $past(nv_wipe_guard_off_i))
    else $error("Erase-protection bit not taken from setting.");
  a_wipe_on_match: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    full_wipe_start_o |-> $past(keys_match) && !$past(st_reg.match_seen)
    && $past(st_reg.dbg_key) != WORD_ZERO)
    else $error("Erase started without a nonzero key match.");

  // Register write and readback paths of the key and the message word.
  a_key_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    wr && dbg_addr_i == OFS_ERASE_UNLOCK_KEY |=> st_reg.dbg_key == $past(dbg_wdata_i))
    else $error("Unlock key write not taken.");
  a_key_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    dbg_sel_i && !dbg_we_i && dbg_addr_i == OFS_ERASE_UNLOCK_KEY
    |=> dbg_rdata_o == $past(st_reg.dbg_key))
    else $error("Unlock key read wrong.");
  a_msg_readback: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
    dbg_sel_i && !dbg_we_i && dbg_addr_i == OFS_OUTBOUND_MESSAGE
    |=> dbg_rdata_o == $past(st_reg.message))
    else $error("Mailbox word read wrong.");

  // Only a debugger write may change the word; the CPU read leaves it in place.
  a_msg_hold: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE6
    !(wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE) |=> $stable(st_reg.message))
    else $error("Mailbox word changed without a write.");
  a_pend_only_write: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE7
    !st_reg.pending && !(wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE) |=> !st_reg.pending)
    else $error("Pending rose without a mailbox write.");

  // A read strobe alone loads the read register; otherwise it returns to zero.
  a_idle_rdata: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE11
    !(dbg_sel_i && !dbg_we_i) |=> dbg_rdata_o == WORD_ZERO)
    else $error("Read data stood without a read.");
  a_strap_port: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE1
    !st_reg.strap_done |=> st_reg.port_off == $past(nv_port_lockout_off_i)
    && st_reg.secure_off == $past(nv_secure_port_lockout_off_i))
    else $error("Protection bits not taken from settings.");

  // The launch is a single pulse so the eraser never sees a second request.
  a_wipe_single: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    full_wipe_start_o |=> !full_wipe_start_o)
    else $error("Erase start lasted more than one cycle.");
  a_match_wipes: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RULE4
    keys_match && !st_reg.match_seen |=> full_wipe_start_o)
    else $error("Key match did not start the erase.");

  // Main scenarios that the bench is expected to reach.
  c_msg_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE ##[1:20] cpu_msg_rd_i);
  c_wipe: cover property (@(posedge mclk_i) disable iff (!rst_n_i) full_wipe_start_o);
  c_locked: cover property (@(posedge mclk_i) disable iff (!rst_n_i) fw_locked_o && fw_key_we_i);
  c_write_and_read: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr && dbg_addr_i == OFS_OUTBOUND_MESSAGE && cpu_msg_rd_i);
  c_status_write: cover property (@(posedge mclk_i) disable iff (!rst_n_i)
    wr && dbg_addr_i == OFS_WIPE_GUARD_STATUS);
endmodule // dcp_ctrl_port

/* test/dcp_dbg_model.sv */
`timescale 1ns/1ps
// Debugger side; released lines flip so a stale value never looks valid.
module dcp_dbg_model (
  input wire logic mclk_i,
  input wire logic [31:0] dbg_rdata_i,
  output logic dbg_sel_o,
  output logic dbg_we_o,
  output logic [7:0] dbg_addr_o,
  output logic [31:0] dbg_wdata_o
);
  initial begin
    dbg_sel_o = 1'b0;
    dbg_we_o = 1'b0;
    dbg_addr_o = 8'hff;
    dbg_wdata_o = 32'h0;
  end
  // One strobe per access; read data is taken in the cycle in which it stands.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge mclk_i);
    #1;
    dbg_sel_o = 1'b1;
    dbg_we_o = w;
    dbg_addr_o = a;
    dbg_wdata_o = d;
    @(posedge mclk_i);
    #1;
    q = dbg_rdata_i;
    dbg_sel_o = 1'b0;
    dbg_we_o = ~w;
    dbg_addr_o = ~a;
    dbg_wdata_o = ~d;
  endtask
endmodule // dcp_dbg_model

/* test/dcp_ctrl_port_bench.sv */
`timescale 1ns/1ps
module dcp_ctrl_port_bench;
  import dcp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic na = 1'b0, ns = 1'b0, nw = 1'b0, ea, es, ew, crd = 1'b0, fwe = 1'b0, flk = 1'b0;
  logic sel, we, lkd, pend, wipe;
  logic [7:0] addr;
  logic [31:0] wd, rd, msg, fkd = 32'h0, q, d, k;
  logic [7:0] ro_ofs [4];
  logic [31:0] mq [$];
  int error_cnt = 0, samples_checked = 0, wipes = 0, ewipes, epend;
  always #20 mclk_i = ~mclk_i;
  always @(posedge mclk_i) if (wipe === 1'b1) wipes++;
  dcp_ctrl_port DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .dbg_sel_i(sel), .dbg_we_i(we),
    .dbg_addr_i(addr), .dbg_wdata_i(wd), .dbg_rdata_o(rd), .nv_port_lockout_off_i(na),
    .nv_secure_port_lockout_off_i(ns), .nv_wipe_guard_off_i(nw), .cpu_msg_rd_i(crd),
    .cpu_inbound_message_o(msg), .cpu_inbound_pending_o(pend), .fw_key_we_i(fwe),
    .fw_key_wdata_i(fkd), .fw_lock_we_i(flk), .fw_locked_o(lkd), .full_wipe_start_o(wipe));
  dcp_dbg_model u_dbg (.mclk_i(mclk_i), .dbg_rdata_i(rd), .dbg_sel_o(sel), .dbg_we_o(we),
    .dbg_addr_o(addr), .dbg_wdata_o(wd));
  task automatic print_verdict;
    $display("errors %0d checks %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    u_dbg.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    u_dbg.xfer(1'b1, a, v, q);
  endtask
  task automatic fw(input logic lk, input logic [31:0] v);
    @(posedge mclk_i);
    #1;
    fwe = ~lk;
    flk = lk;
    fkd = v;
    @(posedge mclk_i);
    #1;
    fwe = 1'b0;
    flk = 1'b0;
  endtask
  // Checks the status words and the pending word against the model.
  task automatic stat;
    rdc(OFS_PORT_LOCKOUT_STATUS, {30'h0, es, ea});
    rdc(OFS_WIPE_GUARD_STATUS, {31'h0, ew});
    rdc(OFS_OUTBOUND_PENDING_STATUS, 32'(epend));
  endtask
  task automatic wipe_chk;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(32'(wipes), 32'(ewipes));
  endtask
  initial begin
    void'($urandom(32'h00df));
    ro_ofs = '{OFS_PORT_LOCKOUT_STATUS, OFS_WIPE_GUARD_STATUS,
               OFS_OUTBOUND_PENDING_STATUS, 8'h30};
    for (int r = 0; r < 2; r++) begin
      rst_n_i = 1'b0;
      {ea, es, ew} = 3'($urandom);
      {na, ns, nw} = {ea, es, ew};
      repeat (4) @(posedge mclk_i);
      #1;
      wipes = 0;
      ewipes = 0;
      epend = 0;
      mq.delete();
      rst_n_i = 1'b1;
      @(posedge mclk_i);
      #1;
      // Settings are taken once, so later changes must not show.
      {na, ns, nw} = ~{ea, es, ew};
      chk({31'h0, lkd}, 32'h0);
      chk({31'h0, pend}, 32'h0);
      stat;
      rdc(OFS_ERASE_UNLOCK_KEY, KEY_RESET);
      rdc(OFS_OUTBOUND_MESSAGE, MSG_RESET);
      foreach (ro_ofs[i]) begin
        wr(ro_ofs[i], $urandom);
      end
      stat;
      rdc(8'h30, WORD_ZERO);
      for (int m = 0; m < 3; m++) begin
        d = $urandom;
        wr(OFS_OUTBOUND_MESSAGE, d);
        mq.push_back(d);
        epend = (mq.size() != 0);
        chk({31'h0, pend}, 32'(epend));
        chk(msg, mq[$]);
        rdc(OFS_OUTBOUND_MESSAGE, mq[$]);
        stat;
      end
      @(posedge mclk_i);
      #1;
      crd = 1'b1;
      @(posedge mclk_i);
      #1;
      crd = 1'b0;
      mq.delete();
      epend = 0;
      chk({31'h0, pend}, 32'(epend));
      stat;
      // A CPU read in the very cycle of a debugger write must not lose the new word.
      d = $urandom;
      fork
        wr(OFS_OUTBOUND_MESSAGE, d);
        begin
          @(posedge mclk_i);
          #1;
          crd = 1'b1;
          @(posedge mclk_i);
          #1;
          crd = 1'b0;
        end
      join
      mq.delete();
      mq.push_back(d);
      epend = (mq.size() != 0);
      chk({31'h0, pend}, 32'(epend));
      chk(msg, mq[$]);
      stat;
      k = $urandom | 32'h1;
      fw(1'b0, k);
      wr(OFS_ERASE_UNLOCK_KEY, k ^ 32'h2);
      wipe_chk;
      wr(OFS_ERASE_UNLOCK_KEY, k);
      ewipes++;
      wipe_chk;
      rdc(OFS_ERASE_UNLOCK_KEY, k);
      fw(1'b0, 32'h0);
      wr(OFS_ERASE_UNLOCK_KEY, 32'h0);
      wipe_chk;
      fw(1'b1, 32'h0);
      chk({31'h0, lkd}, 32'h1);
      fw(1'b0, k);
      wr(OFS_ERASE_UNLOCK_KEY, k);
      wipe_chk;
    end
    print_verdict;
  end
  initial begin
    #400000;
    error_cnt++;
    print_verdict;
  end
endmodule // dcp_ctrl_port_bench
